//--- bist_pkg.sv
// constants for the self-test checker: register map, fields, widths
// assumes an 8-bit register port and a 35-bit recovered frame payload
package bist_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PAYLOAD_W = 35;
  localparam int COUNT_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h24;
  localparam logic [7:0] ADDR_FWD_ERR = 8'h25;
  localparam logic [7:0] ADDR_STATUS = 8'h26;

  // config register fields and reset value
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_OSC_BIT = 1;
  localparam int CFG_USED_W = 2;
  localparam logic [1:0] CONFIG_RESET = 2'h0;

  // status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_RESULT_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_FAILED_BIT = 3;
  localparam int STAT_CHECKING_BIT = 4;

  // counter limits and read filler
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

//--- chk_link_if.sv
// carrier between the top and its payload checker and error tally
// assumes all users run on the same core clock
`timescale 1ns/1ps
interface chk_link_if;
  logic                               ce;
  logic                               frame_valid;
  logic [bist_pkg::PAYLOAD_W-1:0]     payload;
  logic                               checking;
  logic                               frame_err;
  logic                               clear;
  logic [bist_pkg::COUNT_W-1:0]       count;

  modport top (
    output ce,
    output frame_valid,
    output payload,
    output checking,
    output clear,
    input  frame_err,
    input  count
  );
  modport zero_chk (
    input  ce,
    input  frame_valid,
    input  payload,
    input  checking,
    output frame_err
  );
  modport tally (
    input  ce,
    input  frame_err,
    input  clear,
    output count
  );
endinterface

//--- error_tally.sv
// saturating count of frames that carried errors
// assumes clear comes from the top on test start or lock loss
`timescale 1ns/1ps
module error_tally (
  input  wire logic     clk,
  input  wire logic     rst_n,
  chk_link_if.tally     lnk
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // an error in the clearing cycle still counts, so set beats clear
  // record errored frames
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lnk.count <= bist_pkg::COUNT_ZERO;
    else if (lnk.ce)
    begin
      if (lnk.clear)
        lnk.count <= lnk.frame_err ? bist_pkg::COUNT_ONE
                                   : bist_pkg::COUNT_ZERO;
      else if (lnk.frame_err && lnk.count != bist_pkg::COUNT_MAX)
        lnk.count <= lnk.count + bist_pkg::COUNT_ONE;
    end
  end

  AST_SATURATE: assert property (
    (lnk.ce && !lnk.clear && lnk.count == bist_pkg::COUNT_MAX)
      |=> lnk.count == bist_pkg::COUNT_MAX)
    else $error("error count wrapped");
  AST_COUNT_STEP: assert property (
    (lnk.ce && !lnk.clear && lnk.frame_err
      && lnk.count != bist_pkg::COUNT_MAX)
      |=> lnk.count == $past(lnk.count) + bist_pkg::COUNT_ONE)
    else $error("errored frame not recorded");
endmodule

//--- frame_zero_checker.sv
// compares each recovered frame payload against all zeros
// assumes frame_valid is a one-cycle strobe per received frame
`timescale 1ns/1ps
module frame_zero_checker (
  input  wire logic     clk,
  input  wire logic     rst_n,
  chk_link_if.zero_chk  lnk
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // one registered error flag per checked frame
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lnk.frame_err <= 1'b0;
    else if (lnk.ce)
      lnk.frame_err <= lnk.checking && lnk.frame_valid && (|lnk.payload);
  end

  AST_MISMATCH_FLAGGED: assert property (
    (lnk.ce && lnk.checking && lnk.frame_valid && (|lnk.payload))
      |=> lnk.frame_err)
    else $error("nonzero payload not flagged");
  AST_ZERO_FRAME_CLEAN: assert property (
    (lnk.ce && lnk.frame_valid && lnk.payload == '0) |=> !lnk.frame_err)
    else $error("zero payload flagged as error");
endmodule

//--- remote_serializer_model.sv
// serializer stand-in: answers the test request and sends frames
// assumes one frame slot every fourth core cycle is fast enough
`timescale 1ns/1ps
module remote_serializer_model (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           test_req,
  input  wire logic [bist_pkg::PAYLOAD_W-1:0] err_mask,
  input  wire logic                           bc_err,
  output logic      [7:0]                     bc_err_count,
  output logic                                in_test,
  output logic                                frame_valid,
  output logic      [bist_pkg::PAYLOAD_W-1:0] payload
);
  logic [1:0] phase;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      in_test <= 1'b0;
    else
      in_test <= test_req;
  end

  // back-channel crc tally, cleared on test entry
  // counts only in test and keeps the last run's value afterwards
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bc_err_count <= 8'h00;
    else if (test_req && !in_test)
      bc_err_count <= 8'h00;
    else if (in_test && phase == 2'h3 && bc_err)
      bc_err_count <= bc_err_count + 8'h01;
  end

  // zero payload frames
  // the mask stands for line errors that the bench asks for
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase       <= 2'h0;
      frame_valid <= 1'b0;
      payload     <= '0;
    end
    else
    begin
      phase       <= phase + 2'h1;
      frame_valid <= in_test && (phase == 2'h3);
      // toggles between frames so a stale frame never looks valid
      payload     <= (in_test && phase == 2'h3) ? err_mask : ~payload;
    end
  end
endmodule

//--- serial_link_bist_checker.sv
// deserializer-side self test of the serial link: request, check, result
// assumes all inputs synchronous to I_CORE_CLK; frame strobe per frame
`timescale 1ns/1ps
module serial_link_bist_checker (
  input  wire logic                           I_CORE_CLK,
  input  wire logic                           I_ARST_N,
  input  wire logic                           I_CLK_EN,
  input  wire logic [bist_pkg::ADDR_W-1:0]    I_ADDR,
  input  wire logic [bist_pkg::DATA_W-1:0]    I_WDATA,
  input  wire logic                           I_WR,
  input  wire logic                           I_RD,
  output logic      [bist_pkg::DATA_W-1:0]    O_RDATA,
  input  wire logic                           I_SELF_TEST_ENABLE_PIN,
  input  wire logic                           I_SELF_TEST_CLOCK_SELECT_PIN,
  input  wire logic                           I_LOCK,
  input  wire logic                           I_REMOTE_IN_TEST,
  input  wire logic                           I_FRAME_VALID,
  input  wire logic [bist_pkg::PAYLOAD_W-1:0] I_FRAME_PAYLOAD,
  output logic                                O_BACK_CHANNEL_TEST_REQ,
  output logic                                O_USE_INTERNAL_OSCILLATOR,
  output logic                                O_RESULT,
  output logic                                O_LOCK,
  output logic                                O_EQUALIZER_ADVANCE
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_LOCK, ST_CHECK} state_e;

  state_e                           state;
  state_e                           next_state;
  logic [bist_pkg::CFG_USED_W-1:0]  config_reg;
  logic                             test_req;
  logic                             start;
  logic                             leave;
  logic                             lock_drop;
  logic                             enter_check;
  logic                             failed;
  logic                             checked;
  logic [bist_pkg::DATA_W-1:0]      status_word;

  chk_link_if lnk ();

  // address match shared by write and read decode
  function automatic logic hit(input logic [bist_pkg::ADDR_W-1:0] a,
                               input logic [bist_pkg::ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  assign test_req = I_SELF_TEST_ENABLE_PIN
                  | config_reg[bist_pkg::CFG_ENABLE_BIT];

  // sequencing events
  assign start = (state == ST_IDLE) && test_req;
  assign leave = (state != ST_IDLE) && !test_req;
  assign lock_drop = (state == ST_CHECK) && test_req && !I_LOCK;
  assign enter_check = (state == ST_WAIT_LOCK) && (next_state == ST_CHECK);

  // sub-block wiring
  assign lnk.ce = I_CLK_EN;
  // only frames seen while locked are meaningful
  assign lnk.frame_valid = I_FRAME_VALID && I_LOCK;
  assign lnk.payload = I_FRAME_PAYLOAD;
  // a frame in the ending cycle belongs to no run, so it is not checked
  assign lnk.checking = (state == ST_CHECK) && test_req;
  // lock loss or new test clears
  assign lnk.clear = start || lock_drop;

  frame_zero_checker u_checker (
    .clk   (I_CORE_CLK),
    .rst_n (I_ARST_N),
    .lnk   (lnk.zero_chk)
  );

  error_tally u_tally (
    .clk   (I_CORE_CLK),
    .rst_n (I_ARST_N),
    .lnk   (lnk.tally)
  );

  // test sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (test_req)
          next_state = ST_WAIT_LOCK;
      ST_WAIT_LOCK:
        if (!test_req)
          next_state = ST_IDLE;
        // both ends in test and locked
        else if (I_LOCK && I_REMOTE_IN_TEST)
          next_state = ST_CHECK;
      ST_CHECK:
        if (!test_req)
          next_state = ST_IDLE;
        else if (!I_LOCK)
          next_state = ST_WAIT_LOCK;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      state <= ST_IDLE;
    else if (I_CLK_EN)
      state <= next_state;
  end

  // run history; errors from the last check cycle still count
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      failed <= 1'b0;
      checked <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      if (start)
      begin
        failed <= 1'b0;
        checked <= 1'b0;
      end
      else
      begin
        if (lnk.frame_err)
          failed <= 1'b1;
        if (enter_check)
          checked <= 1'b1;
      end
    end
  end

  // result pin: low until the run's first lock, pulses low on errors, then held
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_RESULT <= 1'b0;
    else if (I_CLK_EN)
    begin
      if (start)
        O_RESULT <= 1'b0;
      else if (enter_check)
        O_RESULT <= 1'b1;
      else if (state == ST_CHECK && test_req)
        O_RESULT <= !lnk.frame_err;
      else if (leave)
        O_RESULT <= checked && !failed && !lnk.frame_err;
    end
  end

  // back-channel request and equalizer step
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_BACK_CHANNEL_TEST_REQ <= 1'b0;
      O_EQUALIZER_ADVANCE <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      O_BACK_CHANNEL_TEST_REQ <= (next_state != ST_IDLE);
      O_EQUALIZER_ADVANCE <= leave;
    end
  end

  // lock mirror and clock choice, both plain levels
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_LOCK <= 1'b0;
      O_USE_INTERNAL_OSCILLATOR <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      O_LOCK <= I_LOCK;
      O_USE_INTERNAL_OSCILLATOR <= I_SELF_TEST_CLOCK_SELECT_PIN
                                 | config_reg[bist_pkg::CFG_OSC_BIT];
    end
  end

  // config register write
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      config_reg <= bist_pkg::CONFIG_RESET;
    else if (I_CLK_EN && I_WR && hit(I_ADDR, bist_pkg::ADDR_CONFIG))
      config_reg <= I_WDATA[bist_pkg::CFG_USED_W-1:0];
  end

  // live status word
  always_comb
  begin
    status_word = bist_pkg::READ_ZERO;
    status_word[bist_pkg::STAT_ACTIVE_BIT] = (state != ST_IDLE);
    status_word[bist_pkg::STAT_RESULT_BIT] = O_RESULT;
    status_word[bist_pkg::STAT_LOCK_BIT] = O_LOCK;
    status_word[bist_pkg::STAT_FAILED_BIT] = failed;
    status_word[bist_pkg::STAT_CHECKING_BIT] = (state == ST_CHECK);
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_RDATA <= bist_pkg::READ_ZERO;
    else if (I_CLK_EN)
    begin
      if (!I_RD)
        O_RDATA <= bist_pkg::READ_ZERO;
      else if (hit(I_ADDR, bist_pkg::ADDR_FWD_ERR))
        O_RDATA <= lnk.count;
      else if (hit(I_ADDR, bist_pkg::ADDR_CONFIG))
        O_RDATA <= {{(bist_pkg::DATA_W-bist_pkg::CFG_USED_W){1'b0}},
                    config_reg};
      else if (hit(I_ADDR, bist_pkg::ADDR_STATUS))
        O_RDATA <= status_word;
      else
        O_RDATA <= bist_pkg::READ_ZERO;
    end
  end

  // named steps of the test
  sequence s_start;
    I_CLK_EN && state == ST_IDLE && test_req;
  endsequence
  sequence s_lock_ready;
    I_CLK_EN && state == ST_WAIT_LOCK && test_req && I_LOCK
      && I_REMOTE_IN_TEST;
  endsequence
  sequence s_err_seen;
    I_CLK_EN && state == ST_CHECK && test_req && lnk.frame_err;
  endsequence

  AST_ENTER_TEST: assert property (
    s_start |=> state == ST_WAIT_LOCK)
    else $error("request did not start test");
  AST_BACKCH_REQ: assert property (
    s_start |=> O_BACK_CHANNEL_TEST_REQ && !O_RESULT)
    else $error("back channel request missing");
  AST_RESULT_HIGH: assert property (
    s_lock_ready |=> O_RESULT && state == ST_CHECK)
    else $error("result not high at lock");
  AST_ERR_PULSE: assert property (
    s_err_seen |=> !O_RESULT)
    else $error("errored frame gave no low pulse");
  AST_LOCK_CLEAR: assert property (
    (I_CLK_EN && lock_drop && !lnk.frame_err) |=> lnk.count == '0)
    else $error("count not cleared on lock loss");
  AST_HOLD_RESULT: assert property (
    (I_CLK_EN && state == ST_IDLE && !test_req) |=> $stable(O_RESULT))
    else $error("held result changed");
  AST_LOCK_VALID: assert property (
    I_CLK_EN |=> O_LOCK == $past(I_LOCK))
    else $error("lock output stale");
  AST_EQ_STEP: assert property (
    (I_CLK_EN && leave) |=> O_EQUALIZER_ADVANCE ##1 !O_EQUALIZER_ADVANCE
      or (!I_CLK_EN))
    else $error("equalizer step missing");
  AST_READ_COUNT: assert property (
    (I_CLK_EN && I_RD && I_ADDR == bist_pkg::ADDR_FWD_ERR)
      |=> O_RDATA == $past(lnk.count))
    else $error("error count read wrong");
endmodule

//--- serial_link_bist_checker_tb_top.sv
// bench for the self-test checker with a serializer stand-in
// assumes one core clock; random masks from an lfsr started at 92
`timescale 1ns/1ps
module serial_link_bist_checker_tb_top;
  localparam int LIMIT = 20000;
  logic        clk, arst_n, wr, rd, pin, csel, lock, fv, rit;
  logic        req, osc, res, lko, adv, chk_on, res_q, lk_q, ce, bce;
  logic [7:0]  addr, wdata, rdata, r, v, bcc;
  logic [34:0] mask, pay;
  int          err_count, n_checks, cyc, pulses, longs, nerr, adv_n, nbc;

  serial_link_bist_checker u_serial_link_bist_checker (
    .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_CLK_EN(ce),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_SELF_TEST_ENABLE_PIN(pin), .I_SELF_TEST_CLOCK_SELECT_PIN(csel),
    .I_LOCK(lock), .I_REMOTE_IN_TEST(rit), .I_FRAME_VALID(fv),
    .I_FRAME_PAYLOAD(pay), .O_BACK_CHANNEL_TEST_REQ(req),
    .O_USE_INTERNAL_OSCILLATOR(osc), .O_RESULT(res), .O_LOCK(lko),
    .O_EQUALIZER_ADVANCE(adv)
  );

  remote_serializer_model u_remote_serializer_model (
    .clk(clk), .rst_n(arst_n), .test_req(req), .err_mask(mask),
    .in_test(rit), .frame_valid(fv), .payload(pay),
    .bc_err(bce), .bc_err_count(bcc)
  );

  // free-running core clock, 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [34:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // register port: one-cycle strobes, data the cycle after a read
  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // waits for the pass pin to rise, then starts watching pulses
  task automatic arm();
    int k;
    k = 0;
    while (res !== 1'b1 && k < 8)
    begin
      @(posedge clk);
      #1 k++;
    end
    check("result_high", res, 1'b1);
    nerr = 0;
    pulses = 0;
    longs = 0;
    chk_on = 1'b1;
  endtask

  // straps sit outside this block; the board holds them set
  task automatic start_test(input logic by_pin);
    nbc = 0;
    @(posedge clk);
    lock <= 1'b0;
    if (by_pin)
      pin <= 1'b1;
    else
      reg_wr(8'h24, 8'h01);
    repeat (3) @(posedge clk);
    #1 check("bc_req", req, 1'b1);
    check("result_unlocked", res, 1'b0);
    @(posedge clk);
    lock <= 1'b1;
    arm();
  endtask

  // mode 0 clean, 1 random errors, 2 every frame errored
  task automatic send(input int n, input int mode);
    logic [34:0] m;
    for (int i = 0; i < n; i++)
    begin
      r = lfsr(r);
      m = (mode == 2 || (mode == 1 && r[0])) ? 35'h1 << (r % 35) : 35'h0;
      // corner bit positions first
      if (mode != 0 && i < 2)
        m = 35'h1 << (i * 34);
      nerr += (m != 35'h0);
      nbc += r[1];
      @(posedge clk);
      while (fv !== 1'b1)
        @(posedge clk);
      mask <= m;
      bce  <= r[1];
    end
    @(posedge clk);
    while (fv !== 1'b1)
      @(posedge clk);
    mask <= 35'h0;
    bce  <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic end_test(input logic by_pin, input logic exp);
    chk_on = 1'b0;
    check("pulse_count", pulses, nerr);
    check("long_low", longs, 0);
    adv_n = 0;
    if (by_pin)
    begin
      @(posedge clk);
      pin <= 1'b0;
    end
    else
      reg_wr(8'h24, 8'h00);
    repeat (6) @(posedge clk);
    #1 check("eq_advance", adv_n, 1);
    check("held_result", res, exp);
    check("bc_req_off", req, 1'b0);
    check("bc_crc_count", bcc, nbc[7:0]);
    reg_rd(8'h25, v);
    check("fwd_count", v, nerr > 255 ? 8'hff : nerr[7:0]);
    reg_rd(8'h26, v);
    check("status", v, {4'h0, ~exp, 1'b1, exp, 1'b0});
  endtask

  // background watch: lock copy, pulse shapes, equalizer step, timeout
  always @(posedge clk)
  begin
    if (arst_n)
      check("lock_copy", lko, lk_q);
    lk_q = lock;
    if (chk_on && res_q && !res)
      pulses++;
    if (chk_on && !res_q && !res)
      longs++;
    if (adv === 1'b1)
      adv_n++;
    res_q = res;
    cyc++;
    if (cyc == LIMIT)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    {arst_n, wr, rd, pin, csel, lock, chk_on, res_q, lk_q, bce} = '0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    mask = 35'h0;
    r = 8'h5c;
    {err_count, n_checks, cyc, pulses, longs, nerr, adv_n, nbc} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    reg_rd(8'h24, v);
    check("cfg_reset", v, 8'h00);
    reg_rd(8'h25, v);
    check("count_reset", v, 8'h00);
    reg_rd(8'h30, v);
    check("unmapped", v, 8'h00);
    check("result_reset", res, 1'b0);
    // every pin and bit combination of the clock choice
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      csel <= k[0];
      reg_wr(8'h24, {6'h0, k[1], 1'b0});
      repeat (2) @(posedge clk);
      #1 check("osc_select", osc, k[0] | k[1]);
    end
    // a write while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(8'h24, 8'h01);
    @(posedge clk);
    ce <= 1'b1;
    reg_rd(8'h24, v);
    check("ce_freeze", v, 8'h02);
    // pin-run test with errors, then a refused count write
    start_test(1'b1);
    send(12, 1);
    end_test(1'b1, 1'b0);
    reg_wr(8'h25, 8'h55);
    reg_rd(8'h25, v);
    check("count_ro", v, nerr[7:0]);
    // register-run clean test
    start_test(1'b0);
    reg_rd(8'h24, v);
    check("cfg_readback", v, 8'h01);
    send(6, 0);
    end_test(1'b0, 1'b1);
    // lock lost in mid-run clears the count
    start_test(1'b1);
    send(4, 1);
    chk_on = 1'b0;
    @(posedge clk);
    lock <= 1'b0;
    repeat (3) @(posedge clk);
    reg_rd(8'h25, v);
    check("count_lock_loss", v, 8'h00);
    @(posedge clk);
    lock <= 1'b1;
    arm();
    send(3, 1);
    end_test(1'b1, 1'b0);
    // heavy burst saturates the count
    start_test(1'b0);
    send(260, 2);
    end_test(1'b0, 1'b0);
    print_verdict();
  end
endmodule
